// >>> hdl/cmc_mode_control.v
// CAN mode control: init-halt, sleep handshake, power-down, timer link, AHB-Lite registers
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cmc_regs.vh"
module cmc_mode_control (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire cpu_stop,
  input wire cpu_wait,
  input wire bit_tick,
  input wire proto_tx_bit,
  input wire proto_busy,
  input wire bus_rx_pin,
  output reg bus_tx_pin,
  output reg proto_abort,
  output reg proto_enable,
  input wire can_timer_out,
  input wire port_timer_pin,
  output reg timer_input
);

  localparam ST_HALT = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_SLEEP_WAIT = 2'b10;
  localparam ST_SLEEP = 2'b11;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg init_halt_request;
  reg sleep_request;
  reg stop_in_wait;
  reg timer_link_enable;
  reg power_down;
  reg prev_halt;
  reg wr_pend_reg;
  reg [11:0] addr_reg;
  wire bus_synced_flag;
  wire sleep_ack;
  wire active;
  wire pd_now;

  // ---------------------------------------------------------------
  // Power-down detection
  // ---------------------------------------------------------------
  assign pd_now = cpu_stop | (cpu_wait & stop_in_wait);
  assign sleep_ack = (state_reg == ST_SLEEP);
  assign active = (state_reg == ST_RUN || state_reg == ST_SLEEP_WAIT) && !power_down;

  function [7:0] mode_byte;
    input dummy;
    begin
      mode_byte = 8'h00;
      mode_byte[`CMC_BIT_INIT_HALT] = init_halt_request;
      mode_byte[`CMC_BIT_SLEEP_REQ] = sleep_request;
      mode_byte[`CMC_BIT_SLEEP_ACK] = sleep_ack;
      mode_byte[`CMC_BIT_TLINK_EN] = timer_link_enable;
      mode_byte[`CMC_BIT_SYNCED] = bus_synced_flag;
      mode_byte[`CMC_BIT_STOP_WAIT] = stop_in_wait;
    end
  endfunction

  cmc_sync_detect u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!active),
    .bit_tick(bit_tick),
    .rx_bit(bus_rx_pin),
    .synced(bus_synced_flag)
  );

  // ---------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_HALT:
        if (!init_halt_request)
          state_next = sleep_request ? ST_SLEEP : ST_RUN;
      ST_RUN:
        if (init_halt_request)
          state_next = ST_HALT;
        else if (sleep_request)
          state_next = ST_SLEEP_WAIT;
      ST_SLEEP_WAIT:
        if (init_halt_request)
          state_next = ST_HALT;
        else if (!sleep_request)
          state_next = ST_RUN;
        else if (!proto_busy)
          state_next = ST_SLEEP;
      default:
        if (init_halt_request)
          state_next = ST_HALT;
        else if (!sleep_request)
          state_next = ST_RUN;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_HALT;
      power_down <= 1'b0;
      prev_halt <= 1'b1;
    end
    else
    begin
      power_down <= pd_now;
      prev_halt <= init_halt_request;
      if (!power_down)
        state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Bus-facing outputs
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_tx_pin <= `CMC_RECESSIVE;
      proto_abort <= 1'b0;
      proto_enable <= 1'b0;
      timer_input <= 1'b0;
    end
    else
    begin
      if (pd_now || init_halt_request || state_next == ST_HALT)
        bus_tx_pin <= `CMC_RECESSIVE;
      else if (state_next == ST_SLEEP)
        bus_tx_pin <= `CMC_RECESSIVE;
      else
        bus_tx_pin <= proto_tx_bit;
      proto_abort <= (pd_now && !power_down) || (init_halt_request && !prev_halt);
      proto_enable <= !pd_now && !init_halt_request &&
        (state_next == ST_RUN || state_next == ST_SLEEP_WAIT);
      timer_input <= timer_link_enable ? can_timer_out : port_timer_pin;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      init_halt_request <= 1'b1;
      sleep_request <= 1'b0;
      stop_in_wait <= 1'b1;
      timer_link_enable <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (wr_pend_reg && !power_down && addr_reg == `CMC_MODE_CTRL_ADDR)
      begin
        init_halt_request <= hwdata[`CMC_BIT_INIT_HALT];
        sleep_request <= hwdata[`CMC_BIT_SLEEP_REQ];
        stop_in_wait <= hwdata[`CMC_BIT_STOP_WAIT];
        timer_link_enable <= hwdata[`CMC_BIT_TLINK_EN];
      end
      wr_pend_reg <= 1'b0;
      if (hsel && hready && htrans[1])
      begin
        addr_reg <= haddr[11:0];
        wr_pend_reg <= hwrite;
        if (hwrite || power_down)
          hrdata <= 32'h00000000;
        else if (haddr[11:0] == `CMC_MODE_CTRL_ADDR)
          hrdata <= {24'h000000, mode_byte(1'b0)};
        else if (haddr[11:0] == `CMC_STATUS_ADDR)
          hrdata <= {30'h00000000, proto_busy, power_down};
        else
          hrdata <= 32'h00000000;
      end
    end
  end

endmodule

// >>> hdl/cmc_regs.vh
// Register offsets, field positions, reset values and timing counts for the CAN mode control
`ifndef CMC_REGS_VH
`define CMC_REGS_VH

`define CMC_MODE_CTRL_ADDR 12'h100
`define CMC_STATUS_ADDR 12'h104
`define CMC_MODE_CTRL_RESET 8'h21

`define CMC_BIT_INIT_HALT 0
`define CMC_BIT_SLEEP_REQ 1
`define CMC_BIT_SLEEP_ACK 2
`define CMC_BIT_TLINK_EN 3
`define CMC_BIT_SYNCED 4
`define CMC_BIT_STOP_WAIT 5

`define CMC_STAT_POWER_DOWN 0
`define CMC_STAT_BUSY 1

`define CMC_SYNC_BITS 11
`define CMC_RECESSIVE 1'b1

`endif

// >>> hdl/cmc_sync_detect.v
// Bus idle detector: counts consecutive recessive bits to declare synchronization
`timescale 1ns/1ps
`include "cmc_regs.vh"
module cmc_sync_detect (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire bit_tick,
  input wire rx_bit,
  output reg synced
);

  reg [3:0] count_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= 4'h0;
      synced <= 1'b0;
    end
    else if (clear)
    begin
      count_reg <= 4'h0;
      synced <= 1'b0;
    end
    else if (bit_tick)
    begin
      if (rx_bit != `CMC_RECESSIVE)
        count_reg <= 4'h0;
      else if (count_reg != 4'hF)
        count_reg <= count_reg + 4'h1;
      if ({28'h0000000, count_reg} >= (`CMC_SYNC_BITS - 1) && rx_bit == `CMC_RECESSIVE)
        synced <= 1'b1;
    end
  end

endmodule

// >>> test/cmc_mode_control_monitor.sv
// Checker for the mode control ports
`timescale 1ns/1ps
module cmc_mode_control_monitor (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire cpu_stop,
  input wire cpu_wait,
  input wire bus_tx_pin,
  input wire proto_abort,
  input wire proto_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst; $rose(rst_n) |-> !proto_enable && bus_tx_pin; endproperty
  a_rst: assert property (p_rst) else $error("not halted after reset");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");
  property p_pd_tx; cpu_stop [*2] |-> bus_tx_pin; endproperty
  a_pd_tx: assert property (p_pd_tx) else $error("tx dominant in power-down");
  property p_pd_off; cpu_stop [*2] |-> !proto_enable; endproperty
  a_pd_off: assert property (p_pd_off) else $error("engine enabled in power-down");
  property p_pd_rd;
    cpu_stop [*2] ##0 (hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0;
  endproperty
  a_pd_rd: assert property (p_pd_rd) else $error("read in power-down not zero");
  property p_pd_abort; $rose(cpu_stop) && !cpu_wait |-> ##[0:2] proto_abort; endproperty
  a_pd_abort: assert property (p_pd_abort) else $error("no abort on power-down");
  property p_pulse; proto_abort |=> !proto_abort; endproperty
  a_pulse: assert property (p_pulse) else $error("abort longer than a cycle");
  property p_halt_tx; !proto_enable [*2] |-> bus_tx_pin; endproperty
  a_halt_tx: assert property (p_halt_tx) else $error("tx dominant while off bus");
  c_abort: cover property (proto_abort);
  c_stop: cover property (cpu_stop [*2]);
  c_write: cover property (hsel && htrans[1] && hwrite);
endmodule

// >>> test/cmc_can_bus_model.sv
// Far-side CAN bus: bit strobe and wired-AND bus level
`timescale 1ns/1ps
module cmc_can_bus_model (
  input wire clk,
  input wire rst_n,
  input wire bus_tx_pin,
  input wire other_dominant,
  output reg bit_tick,
  output wire bus_rx_pin
);
  reg [1:0] div_reg;
  // Any dominant node pulls the bus low
  assign bus_rx_pin = bus_tx_pin & ~other_dominant;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= 2'h0;
      bit_tick <= 1'b0;
    end
    else
    begin
      div_reg <= div_reg + 2'h1;
      bit_tick <= (div_reg == 2'h3);
    end
  end
endmodule

// >>> test/test_can_mode_control_lowpower.sv
// Self-checking bench for the CAN mode control block
`timescale 1ns/1ps
`include "cmc_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module test_can_mode_control_lowpower;
  reg clk = 0, rst_n = 0, hsel = 0, hwrite = 0, cpu_stop = 0, cpu_wait = 0, dom = 0, t = 0;
  reg proto_tx_bit = 1, proto_busy = 0, can_timer_out = 0, port_timer_pin = 0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, bus_tx_pin, proto_abort, proto_enable, timer_input, bit_tick, bus_rx_pin;
  int miscompares = 0, tests_run = 0, aborts = 0, a0, i;
  always #50 clk = ~clk;
  always @(negedge clk) if (proto_abort === 1'b1) aborts++;
  cmc_mode_control cmc_mode_control_i (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpu_stop,
    .cpu_wait, .bit_tick, .proto_tx_bit, .proto_busy, .bus_rx_pin, .bus_tx_pin, .proto_abort,
    .proto_enable, .can_timer_out, .port_timer_pin, .timer_input);
  cmc_can_bus_model cmc_can_bus_model_i (.clk, .rst_n, .bus_tx_pin, .other_dominant(dom),
    .bit_tick, .bus_rx_pin);
  function [31:0] mode(input h, s, a, l, y, w);
    mode = {26'h0, w, y, l, a, s, h};
  endfunction
  task ahb(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
    end
  endtask
  task tally_and_finish;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    #(100 * 20000);
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    i = $urandom(20);
    repeat (4) @(posedge clk);
    rst_n <= 1;
    ahb(`CMC_MODE_CTRL_ADDR, 0, 0);
    `CHK(rd, {24'h0, `CMC_MODE_CTRL_RESET})
    ahb(12'h108, 0, 0);
    `CHK(rd, 32'h0)
    for (i = 0; i < 8; i++)
    begin
      t = $urandom;
      ahb(`CMC_MODE_CTRL_ADDR, 1, mode(1, 0, 0, t, 0, 1));
      can_timer_out <= $urandom;
      port_timer_pin <= $urandom;
      dom <= $urandom;
      proto_tx_bit <= $urandom;
      repeat (2) @(posedge clk);
      `CHK(timer_input, t ? can_timer_out : port_timer_pin)
      ahb(`CMC_MODE_CTRL_ADDR, 0, 0);
      `CHK(rd, mode(1, 0, 0, t, 0, 1))
    end
    dom <= 0;
    proto_tx_bit <= 1;
    ahb(`CMC_MODE_CTRL_ADDR, 1, mode(0, 0, 0, 0, 0, 1));
    repeat (60) @(posedge clk);
    ahb(`CMC_MODE_CTRL_ADDR, 0, 0);
    `CHK(rd, mode(0, 0, 0, 0, 1, 1))
    proto_busy <= 1;
    a0 = aborts;
    ahb(`CMC_MODE_CTRL_ADDR, 1, mode(1, 0, 0, 0, 0, 1));
    repeat (2) @(posedge clk);
    `CHK(aborts - a0, 1)
    ahb(`CMC_MODE_CTRL_ADDR, 1, mode(0, 0, 0, 0, 0, 1));
    a0 = aborts;
    proto_tx_bit <= 0;
    cpu_wait <= 1;
    repeat (3) @(posedge clk);
    `CHK(bus_tx_pin, 1'b1)
    `CHK(aborts - a0, 1)
    ahb(`CMC_MODE_CTRL_ADDR, 1, mode(1, 0, 0, 1, 0, 1));
    ahb(`CMC_MODE_CTRL_ADDR, 0, 0);
    `CHK(rd, 32'h0)
    cpu_wait <= 0;
    ahb(`CMC_MODE_CTRL_ADDR, 0, 0);
    `CHK(rd & 32'h2F, mode(0, 0, 0, 0, 0, 1))
    ahb(`CMC_MODE_CTRL_ADDR, 1, mode(0, 0, 0, 0, 0, 0));
    cpu_wait <= 1;
    ahb(`CMC_STATUS_ADDR, 0, 0);
    `CHK(rd, 32'h2)
    cpu_wait <= 0;
    ahb(`CMC_MODE_CTRL_ADDR, 1, mode(0, 1, 0, 0, 0, 1));
    repeat (4) @(posedge clk);
    ahb(`CMC_MODE_CTRL_ADDR, 0, 0);
    `CHK(rd & 32'h2F, mode(0, 1, 0, 0, 0, 1))
    proto_busy <= 0;
    repeat (3) @(posedge clk);
    ahb(`CMC_MODE_CTRL_ADDR, 0, 0);
    `CHK(rd & 32'h2F, mode(0, 1, 1, 0, 0, 1))
    ahb(`CMC_MODE_CTRL_ADDR, 1, mode(1, 1, 0, 0, 0, 1));
    cpu_stop <= 1;
    repeat (3) @(posedge clk);
    `CHK(bus_tx_pin, 1'b1)
    cpu_stop <= 0;
    tally_and_finish;
  end
endmodule
bind cmc_mode_control cmc_mode_control_monitor cmc_mode_control_monitor_i (.clk, .rst_n,
  .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .cpu_stop, .cpu_wait,
  .bus_tx_pin, .proto_abort, .proto_enable);
